// ### hw/isbdr_regs.sv
// isbdr_regs: serial data buffer, baud rate generator and infrared
// encode/decode stage with an APB register port.
// assumes the framer/shifters sit on the same clock and the crystal clock
// and infrared receive pin are asynchronous.
//
// The placing of the registers and the APB slave port were chosen for this implementation.
`timescale 1ns/1ns
module isbdr_regs
  import isbdr_pkg::*;
(
  input  wire logic                      clk,
  input  wire logic                      reset,
  input  wire isbdr_pkg::isbdr_apb_req_t apb_req,
  output isbdr_pkg::isbdr_apb_rsp_t      apb_rsp,
  input  wire logic                      crystal_derived_clock,
  input  wire logic                      tx_take,
  output logic [7:0]                     tx_byte,
  output logic                           tx_pending,
  input  wire logic                      rx_load,
  input  wire logic [7:0]                rx_byte_in,
  input  wire logic                      txd_raw,
  input  wire logic                      tx_bit_strobe,
  output logic                           txd_pin,
  input  wire logic                      ir_rx_pin,
  output logic                           rxd_decoded,
  output logic                           sample_tick
);
  import isbdr_pkg::*;

  isbdr_state_t q;
  isbdr_state_t d;
  logic         setup;
  logic         access;
  logic         hit_data;
  logic         hit_baud;
  logic         hit_ir;
  logic         hit_stat;
  logic         src_tick;
  logic         wrap;
  logic         baud_wr;
  logic         start;
  logic [10:0]  base;
  logic [3:0]   pd;
  logic [7:0]   bd;
  logic [7:0]   status;

  // ----------------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------------
  // zero wait states: data is latched in setup, answered in access
  assign setup    = apb_req.psel & ~apb_req.penable;
  assign access   = apb_req.psel & apb_req.penable;
  assign hit_data = (apb_req.paddr == ADDR_DATA);
  assign hit_baud = (apb_req.paddr == ADDR_BAUD);
  assign hit_ir   = (apb_req.paddr == ADDR_IRCTL);
  assign hit_stat = (apb_req.paddr == ADDR_STATUS);
  assign baud_wr  = access & apb_req.pwrite & hit_baud;
  assign status   = {q.te_flag, 1'b0, q.rf_flag, 5'h00};

  // ----------------------------------------------------------------------
  // baud arithmetic
  // ----------------------------------------------------------------------
  // crystal ticks are edges of the re-synchronised clock, so that source
  // only works while it is slower than half the bus clock
  assign src_tick = q.src_sel ? 1'b1 : (q.xs2 & ~q.xs3);
  assign pd       = isbdr_pd(q.pre_code);
  assign bd       = 8'h01 << q.rate_code;
  assign base     = isbdr_base(q.pre_code, q.rate_code);
  assign wrap     = src_tick & (q.pre_cnt == pd - 4'h1)
                  & (q.rate_cnt == 7'(bd - 8'h01));
  assign start    = tx_bit_strobe & ~txd_raw & q.ir_en;

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb
  begin
    d = q;
    d.tick = 1'b0;
    // synchronisers: first stage is read only by the second
    d.xs1 = crystal_derived_clock;
    d.xs2 = q.xs1;
    d.xs3 = q.xs2;
    d.rs1 = ir_rx_pin;
    d.rs2 = q.rs1;
    d.rs3 = q.rs2;

    // read data is captured in the setup cycle
    if (setup)
    begin
      d.prdata = 32'h0000_0000;
      if (hit_data)
        d.prdata = {24'h00_0000, q.rx_data};
      else if (hit_baud)
        d.prdata = {24'h00_0000, 1'b0, q.src_sel, q.pre_code, 1'b0,
                    q.rate_code};
      else if (hit_ir)
        d.prdata = {24'h00_0000, 5'h00, q.pulse_code, q.ir_en};
      else if (hit_stat)
        d.prdata = {24'h00_0000, status};
    end

    // register writes and read side effects take place at the access edge
    if (access && apb_req.pwrite)
    begin
      if (hit_data)
      begin
        d.tx_data = apb_req.pwdata[7:0];
        if (q.te_armed)
          d.te_flag = 1'b0;
        d.te_armed = 1'b0;
      end
      else if (hit_baud)
      begin
        d.src_sel   = apb_req.pwdata[BAUD_SRC_BIT];
        d.pre_code  = apb_req.pwdata[BAUD_PRE_LSB +: 2];
        d.rate_code = apb_req.pwdata[BAUD_RATE_LSB +: 3];
      end
      else if (hit_ir)
      begin
        d.ir_en      = apb_req.pwdata[IR_EN_BIT];
        d.pulse_code = apb_req.pwdata[IR_PULSE_LSB +: 2];
      end
    end
    else if (access)
    begin
      if (hit_stat)
      begin
        d.te_armed = q.te_flag;
        d.rf_armed = q.rf_flag;
      end
      else if (hit_data)
      begin
        if (q.rf_armed)
          d.rf_flag = 1'b0;
        d.rf_armed = 1'b0;
      end
    end

    // hardware set beats a clear in the same cycle
    if (tx_take)
      d.te_flag = 1'b1;
    if (rx_load)
    begin
      d.rx_data = rx_byte_in;
      d.rf_flag = 1'b1;
    end

    // baud chain: prescaler then power-of-two stage, one tick for both
    // directions; a new setting restarts the chain
    if (baud_wr)
    begin
      d.pre_cnt  = 4'h0;
      d.rate_cnt = 7'h00;
    end
    else if (src_tick)
    begin
      if (q.pre_cnt == pd - 4'h1)
      begin
        d.pre_cnt = 4'h0;
        if (wrap)
        begin
          d.rate_cnt = 7'h00;
          d.tick     = 1'b1;
        end
        else
          d.rate_cnt = q.rate_cnt + 7'h01;
      end
      else
        d.pre_cnt = q.pre_cnt + 4'h1;
    end

    // narrow pulse for every zero bit, length in source ticks
    if (start)
      d.pulse_cnt = isbdr_len(base, q.pulse_code);
    else if (src_tick && q.pulse_cnt != 14'h0000)
      d.pulse_cnt = q.pulse_cnt - 14'h0001;
    if (!q.ir_en)
      d.pulse_cnt = 14'h0000;

    // receive decode: a low pulse becomes a full low bit of 16 samples
    if (q.ir_en && q.rs3 && !q.rs2)
      d.rx_cnt = SAMPLES_PER_BIT;
    else if (q.tick && q.rx_cnt != 5'h00)
      d.rx_cnt = q.rx_cnt - 5'h01;
    if (!q.ir_en)
      d.rx_cnt = 5'h00;

    // pins: encoded while enabled, straight through while bypassed
    d.txd_pin = q.ir_en ? (d.pulse_cnt == 14'h0000) : txd_raw;
    d.rxd     = q.ir_en ? (d.rx_cnt == 5'h00) : q.rs2;

    if (reset)
    begin
      d            = '0;
      d.rx_data    = q.rx_data;
      d.tx_data    = q.tx_data;
      d.src_sel    = SRC_RESET;
      d.pre_code   = PRE_RESET;
      d.rate_code  = RATE_RESET;
      d.ir_en      = INFRARED_ENABLE_RESET;
      d.pulse_code = PULSE_RESET;
      d.te_flag    = TE_RESET;
      d.rf_flag    = RF_RESET;
      d.txd_pin    = 1'b1;
      d.rxd        = 1'b1;
    end
  end

  // single state register
  always_ff @(posedge clk)
  begin
    q <= d;
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign apb_rsp.prdata  = q.prdata;
  assign apb_rsp.pready  = access;
  assign apb_rsp.pslverr = access & ~(hit_data | hit_baud | hit_ir
                                      | hit_stat);
  assign tx_byte     = q.tx_data;
  assign tx_pending  = ~q.te_flag;
  assign txd_pin     = q.txd_pin;
  assign rxd_decoded = q.rxd;
  assign sample_tick = q.tick;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  // source ticks since the last wrap, independent of the chain counters
  logic [10:0] per_cnt_q;
  always_ff @(posedge clk)
  begin
    if (reset || baud_wr || wrap)
      per_cnt_q <= 11'h000;
    else if (src_tick)
      per_cnt_q <= per_cnt_q + 11'h001;
  end

  sequence stat_read_te;
    access && !apb_req.pwrite && hit_stat && q.te_flag;
  endsequence
  sequence data_write;
    access && apb_req.pwrite && hit_data && !tx_take;
  endsequence
  sequence stat_read_rf;
    access && !apb_req.pwrite && hit_stat && q.rf_flag;
  endsequence
  sequence data_read;
    access && !apb_req.pwrite && hit_data && !rx_load;
  endsequence

  data_read_a: assert property (@(posedge clk) disable iff (reset)
    access && !apb_req.pwrite && hit_data && $past(setup)
    |-> apb_rsp.prdata == {24'h00_0000, $past(q.rx_data)})
    else $error("data read did not return received byte");

  tx_write_a: assert property (@(posedge clk) disable iff (reset)
    access && apb_req.pwrite && hit_data && !rx_load
    |=> tx_byte == $past(apb_req.pwdata[7:0]) && $stable(q.rx_data))
    else $error("data write did not load transmit byte only");

  data_keep_a: assert property (@(posedge clk)
    reset && !rx_load |=> $stable(q.rx_data) && $stable(q.tx_data))
    else $error("reset disturbed the data bytes");

  baud_reset_a: assert property (@(posedge clk)
    reset |=> !q.src_sel && q.pre_code == 2'h0 && q.rate_code == 3'h0
              && !q.ir_en && q.pulse_code == 2'h0 && q.te_flag)
    else $error("configuration not cleared by reset");

  bus_src_a: assert property (@(posedge clk) disable iff (reset)
    q.src_sel |-> src_tick)
    else $error("bus clock source not ticking every cycle");

  tick_period_a: assert property (@(posedge clk) disable iff (reset)
    wrap && !baud_wr
    |-> per_cnt_q + 11'h001 == {7'h00, pd} * {3'h0, bd} ##1 sample_tick)
    else $error("sample tick period wrong");

  pulse_wide_a: assert property (@(posedge clk) disable iff (reset)
    start && q.pulse_code == 2'h0
    |=> q.pulse_cnt == 14'($past(base) * 3) ##1 !txd_pin)
    else $error("3/16 pulse length wrong");

  pulse_narrow_a: assert property (@(posedge clk) disable iff (reset)
    start && q.pulse_code[1] && base > 11'h001
    |=> q.pulse_cnt == 14'($past(base) >> 1))
    else $error("1/32 pulse length wrong");

  ir_bypass_a: assert property (@(posedge clk) disable iff (reset)
    !q.ir_en && $past(!q.ir_en)
    |=> txd_pin == $past(txd_raw) && rxd_decoded == $past(q.rs2))
    else $error("bypass path not transparent");

  te_clear_a: assert property (@(posedge clk) disable iff (reset)
    stat_read_te ##1 (!access)[*2] ##1 data_write |=> !q.te_flag)
    else $error("empty flag not cleared by sequence");

  rf_clear_a: assert property (@(posedge clk) disable iff (reset)
    stat_read_rf ##1 (!access)[*2] ##1 data_read |=> !q.rf_flag)
    else $error("full flag not cleared by sequence");

  set_wins_a: assert property (@(posedge clk) disable iff (reset)
    rx_load |=> q.rf_flag && q.rx_data == $past(rx_byte_in))
    else $error("receive load lost against a clear");

endmodule : isbdr_regs

// ### hw/isbdr_pkg.sv
// isbdr_pkg: shared constants, types and lookups for the infrared serial
// data / baud / infrared-control register block.
// assumes a 32-bit APB master and an 8-bit register window on paddr[7:0].
package isbdr_pkg;

  // ----------------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_DATA   = 8'h00;
  localparam logic [7:0] ADDR_BAUD   = 8'h04;
  localparam logic [7:0] ADDR_IRCTL  = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int BAUD_SRC_BIT  = 6;
  localparam int BAUD_PRE_LSB  = 4;
  localparam int BAUD_RATE_LSB = 0;
  localparam int IR_EN_BIT     = 0;
  localparam int IR_PULSE_LSB  = 1;
  localparam int ST_TE_BIT     = 7;
  localparam int ST_RF_BIT     = 5;

  // ----------------------------------------------------------------------
  // reset values and counts
  // ----------------------------------------------------------------------
  localparam logic       SRC_RESET   = 1'b0;
  localparam logic [1:0] PRE_RESET   = 2'h0;
  localparam logic [2:0] RATE_RESET  = 3'h0;
  localparam logic       INFRARED_ENABLE_RESET  = 1'b0;
  localparam logic [1:0] PULSE_RESET = 2'h0;
  localparam logic       TE_RESET    = 1'b1;
  localparam logic       RF_RESET    = 1'b0;
  localparam logic [4:0] SAMPLES_PER_BIT = 5'h10;
  localparam logic [3:0] PD_CODE0 = 4'h1;
  localparam logic [3:0] PD_CODE1 = 4'h3;
  localparam logic [3:0] PD_CODE2 = 4'h4;
  localparam logic [3:0] PD_CODE3 = 4'hD;
  localparam logic [1:0] PULSE_3_16 = 2'h0;
  localparam logic [1:0] PULSE_1_16 = 2'h1;
  localparam logic [13:0] PULSE_MIN = 14'h0001;

  // ----------------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } isbdr_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } isbdr_apb_rsp_t;

  typedef struct packed {
    logic [7:0]  rx_data;
    logic [7:0]  tx_data;
    logic        src_sel;
    logic [1:0]  pre_code;
    logic [2:0]  rate_code;
    logic        ir_en;
    logic [1:0]  pulse_code;
    logic        te_flag;
    logic        te_armed;
    logic        rf_flag;
    logic        rf_armed;
    logic [3:0]  pre_cnt;
    logic [6:0]  rate_cnt;
    logic        tick;
    logic [13:0] pulse_cnt;
    logic [4:0]  rx_cnt;
    logic        xs1;
    logic        xs2;
    logic        xs3;
    logic        rs1;
    logic        rs2;
    logic        rs3;
    logic        txd_pin;
    logic        rxd;
    logic [31:0] prdata;
  } isbdr_state_t;

  // ----------------------------------------------------------------------
  // lookups
  // ----------------------------------------------------------------------
  function automatic logic [3:0] isbdr_pd(input logic [1:0] code);
    logic [3:0] v;
    v = PD_CODE0;
    if (code == 2'h1) v = PD_CODE1;
    else if (code == 2'h2) v = PD_CODE2;
    else if (code == 2'h3) v = PD_CODE3;
    return v;
  endfunction : isbdr_pd

  // source ticks per sample tick: prescale divisor times rate divisor
  function automatic logic [10:0] isbdr_base(input logic [1:0] pc,
                                             input logic [2:0] rc);
    logic [7:0] bd;
    bd = 8'h01 << rc;
    // widen both factors first: 13 * 128 does not fit in eight bits
    return 11'(isbdr_pd(pc)) * 11'(bd);
  endfunction : isbdr_base

  // narrow pulse length in source ticks
  function automatic logic [13:0] isbdr_len(input logic [10:0] base,
                                            input logic [1:0]  code);
    logic [13:0] v;
    v = 14'(base >> 1);
    if (code == PULSE_3_16) v = 14'(base * 3);
    else if (code == PULSE_1_16) v = 14'(base);
    if (v == 14'h0000) v = PULSE_MIN;
    return v;
  endfunction : isbdr_len

endpackage : isbdr_pkg

// ### testbench/isbdr_far_end.sv
// isbdr_far_end: behavioural framer, shifter and infrared line partner.
// assumes clk is the block's bus clock; the crystal runs free beside it.
`timescale 1ns/1ns
module isbdr_far_end
(
  input  wire logic       clk,
  output logic            crystal_derived_clock,
  output logic            tx_take,
  output logic            rx_load,
  output logic [7:0]      rx_byte_in,
  output logic            txd_raw,
  output logic            tx_bit_strobe,
  output logic            ir_rx_pin
);
  // idle line levels at time zero
  initial
  begin
    crystal_derived_clock = 1'b0;
    tx_take = 1'b0;
    rx_load = 1'b0;
    rx_byte_in = 8'h00;
    txd_raw = 1'b1;
    tx_bit_strobe = 1'b0;
    ir_rx_pin = 1'b1;
  end

  // crystal rises on clk rising edges, once every seven clk periods, well under clk/2
  always #35 crystal_derived_clock = ~crystal_derived_clock;

  // received byte handed over; bus scrambles once the load is gone
  task automatic put_rx(input logic [7:0] b);
    @(posedge clk);
    rx_byte_in <= b;
    rx_load <= 1'b1;
    @(posedge clk);
    rx_load <= 1'b0;
    rx_byte_in <= ~b;
  endtask : put_rx

  // shifter takes the pending byte
  task automatic take_tx();
    @(posedge clk);
    tx_take <= 1'b1;
    @(posedge clk);
    tx_take <= 1'b0;
  endtask : take_tx

  // start a zero bit; line stays low until line() raises it
  task automatic send_zero();
    @(posedge clk);
    txd_raw <= 1'b0;
    tx_bit_strobe <= 1'b1;
    @(posedge clk);
    tx_bit_strobe <= 1'b0;
  endtask : send_zero

  task automatic line(input logic v);
    @(posedge clk);
    txd_raw <= v;
  endtask : line

  // infrared receiver sees a low pulse of n cycles
  task automatic ir_fall(input int n);
    @(posedge clk);
    ir_rx_pin <= 1'b0;
    repeat (n) @(posedge clk);
    ir_rx_pin <= 1'b1;
  endtask : ir_fall
endmodule : isbdr_far_end

// ### testbench/tb_top.sv
// tb_top: register, flag, baud and infrared checks over APB.
// assumes isbdr_far_end plays the framer and transceiver side.
`timescale 1ns/1ns
module tb_top;
  import isbdr_pkg::*;
  logic           clk;
  logic           reset;
  isbdr_apb_req_t apb_req;
  isbdr_apb_rsp_t apb_rsp;
  logic           crystal_derived_clock, tx_take, rx_load, txd_raw;
  logic           tx_bit_strobe, ir_rx_pin, tx_pending, txd_pin;
  logic           rxd_decoded, sample_tick;
  logic [7:0]     rx_byte_in, tx_byte;
  logic [31:0]    rd;
  logic           err;
  int             num_errors, check_count, cycles, n, i;
  int             pdv[4] = '{1, 3, 4, 13};
  int             pre[5] = '{0, 1, 2, 3, 0};
  int             rate[5] = '{0, 1, 2, 7, 7};

  isbdr_regs isbdr_regs_inst (.clk, .reset, .apb_req, .apb_rsp,
    .crystal_derived_clock, .tx_take, .tx_byte, .tx_pending, .rx_load,
    .rx_byte_in, .txd_raw, .tx_bit_strobe, .txd_pin, .ir_rx_pin,
    .rxd_decoded, .sample_tick);
  isbdr_far_end isbdr_far_end_inst (.clk, .crystal_derived_clock,
    .tx_take, .rx_load, .rx_byte_in, .txd_raw, .tx_bit_strobe, .ir_rx_pin);

  // ----------------------------------------------------------------------
  // clock, hang guard and reporting
  // ----------------------------------------------------------------------
  initial clk = 1'b0;
  always #5 clk = ~clk;

  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : close_out

  // longest test is a few thousand cycles; this ceiling means a hang
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      close_out();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk

  // ----------------------------------------------------------------------
  // APB master and port samplers
  // ----------------------------------------------------------------------
  // one transfer; ports are looked at after the access edge settles
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    int w;
    @(posedge clk);
    apb_req <= '{1'b1, 1'b0, wr, a, wd};
    @(posedge clk);
    apb_req.penable <= 1'b1;
    w = 0;
    @(posedge clk);
    while (apb_rsp.pready !== 1'b1 && w < 16)
    begin
      @(posedge clk);
      w++;
    end
    rd = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
    if (w >= 16) chk("pready", 1, 0);
    @(negedge clk);
  endtask : apb

  // cycles from one sample tick to the next
  task automatic gap(output int c);
    repeat (2)
    begin
      c = 0;
      @(negedge clk);
      while (sample_tick !== 1'b1 && c < 4000)
      begin
        @(negedge clk);
        c++;
      end
    end
    c++;
  endtask : gap

  function automatic logic sig(input logic rx);
    return rx ? rxd_decoded : txd_pin;
  endfunction : sig

  // length of the next low pulse on txd_pin or rxd_decoded
  task automatic lowlen(input logic rx, output int c);
    c = 0;
    while (sig(rx) !== 1'b0 && c < 64)
    begin
      @(negedge clk);
      c++;
    end
    c = 0;
    while (sig(rx) === 1'b0 && c < 64)
    begin
      @(negedge clk);
      c++;
    end
  endtask : lowlen

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    reset = 1'b1;
    apb_req = '0;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    apb(0, ADDR_BAUD, 0);
    chk("baud reset", 0, rd);
    apb(0, ADDR_IRCTL, 0);
    chk("ir reset", 0, rd);
    apb(1, 8'h10, 32'hFFFFFFFF);
    chk("unmapped err", 1, err);
    apb(0, 8'h10, 0);
    chk("unmapped read", 0, rd);
    apb(1, ADDR_BAUD, 32'hFFFFFFFF);
    apb(0, ADDR_BAUD, 0);
    chk("baud fields", 32'h77, rd);
    apb(1, ADDR_IRCTL, 32'hFFFFFFFF);
    apb(0, ADDR_IRCTL, 0);
    chk("ir fields", 32'h07, rd);
    apb(1, ADDR_STATUS, 0);
    apb(0, ADDR_STATUS, 0);
    chk("status reset", 32'h80, rd);
    $display("test registers done");
    // transmit side: armed write clears empty, unarmed write does not
    apb(1, ADDR_DATA, 32'hA5);
    chk("tx byte", 32'hA5, tx_byte);
    chk("pending", 1, tx_pending);
    isbdr_far_end_inst.take_tx();
    @(negedge clk);
    chk("taken", 0, tx_pending);
    apb(1, ADDR_DATA, 32'h5A);
    chk("unarmed write", 0, tx_pending);
    chk("tx byte", 32'h5A, tx_byte);
    // receive side: data read clears full only after a status read
    isbdr_far_end_inst.put_rx(8'h3C);
    apb(0, ADDR_DATA, 0);
    chk("rx byte", 32'h3C, rd);
    apb(0, ADDR_STATUS, 0);
    chk("full kept", 32'hA0, rd);
    apb(0, ADDR_DATA, 0);
    chk("rx armed read", 32'h3C, rd);
    apb(1, ADDR_DATA, 32'h77);
    apb(0, ADDR_DATA, 0);
    chk("rx not written", 32'h3C, rd);
    apb(0, ADDR_STATUS, 0);
    chk("flags cleared", 0, rd);
    @(posedge clk);
    reset <= 1'b1;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    @(negedge clk);
    chk("tx after reset", 32'h77, tx_byte);
    apb(0, ADDR_DATA, 0);
    chk("rx after reset", 32'h3C, rd);
    $display("test data and flags done");
    // bus clock source: tick every pd*bd cycles, same tick for rx and tx
    for (i = 0; i < 5; i++)
    begin
      apb(1, ADDR_BAUD, 32'h40 | (pre[i] << 4) | rate[i]);
      gap(n);
      chk("tick gap", pdv[pre[i]] << rate[i], n);
    end
    // crystal source: 20 crystal periods fit in 140 cycles
    apb(1, ADDR_BAUD, 0);
    n = 0;
    repeat (140)
    begin
      @(negedge clk);
      if (sample_tick === 1'b1) n++;
    end
    chk("crystal ticks", 1, n >= 19 && n <= 21);
    $display("test baud done");
    // pulse widths with four source ticks per sample tick
    apb(1, ADDR_BAUD, 32'h42);
    for (i = 0; i < 4; i++)
    begin
      apb(1, ADDR_IRCTL, (i << 1) | 1);
      isbdr_far_end_inst.send_zero();
      lowlen(0, n);
      isbdr_far_end_inst.line(1'b1);
      repeat (20) @(posedge clk);
      chk("ir pulse", i == 0 ? 12 : i == 1 ? 4 : 2, n);
    end
    apb(1, ADDR_IRCTL, 0);
    isbdr_far_end_inst.send_zero();
    repeat (3) @(negedge clk);
    chk("bypass low", 0, txd_pin);
    isbdr_far_end_inst.line(1'b1);
    repeat (3) @(negedge clk);
    chk("bypass high", 1, txd_pin);
    // receive decode: one tick per cycle, stretched to 16 ticks
    apb(1, ADDR_BAUD, 32'h40);
    apb(1, ADDR_IRCTL, 1);
    // watch from the start of the pulse, the output may fall before it ends
    fork
      isbdr_far_end_inst.ir_fall(2);
      lowlen(1, n);
    join
    chk("ir rx stretch", 1, n >= 15 && n <= 17);
    apb(1, ADDR_IRCTL, 0);
    fork
      isbdr_far_end_inst.ir_fall(6);
      lowlen(1, n);
    join
    chk("rx bypass", 6, n);
    $display("test infrared done");
    close_out();
  end
endmodule : tb_top
